// ===== hw/uarx_recovery.sv
// Purpose: start bit qualification and majority vote data recovery for an async receiver
// Assumes: SAMPLE_TICK is a one-cycle enable at 16x (normal) or 8x (double) the bit rate
// Notes:   frames go out as one-cycle FRAME_VALID pulses; there is no buffer here
// Notes on behaviour
// - sixteen samples per bit, eight at double speed
// - falling edge on idle line starts; sample one
// - qualify start with samples 8-10 or 4-6
// - two highs among three: noise, search again
// - realign bit timing on every valid start
// - per-bit state counter numbers each sample
// - bit value is majority of centre three
// - recover through first stop bit, ignore rest
// - stop voted zero sets frame error flag
// - next start accepted right after stop vote
// - filter on: data frames are not delivered
// - type bit: stop bit, or ninth bit
// - type one is address, zero is data
// - filter setting touches reception only
// - double speed halves ticks per bit to eight
// - filter enable is a software control bit
module uarx_recovery
  import uarx_pkg::*;
#(
  parameter int SYNC_STAGES = UARX_SYNC_STAGES  // synchroniser depth, two or more
) (
  input  wire logic                  CLK,          // system clock, 250 MHz
  input  wire logic                  RESETN,       // asynchronous reset, active low
  input  wire logic                  SAMPLE_TICK,  // oversampling enable from the baud generator
  input  wire logic                  SERIAL_RX_IN, // receive line, idle high
  input  wire uarx_pkg::uarx_cfg_t   CFG,          // speed, filter, parity and character size
  output logic                       FRAME_VALID,  // one-cycle pulse: FRAME holds a kept frame
  output uarx_pkg::uarx_frame_t      FRAME,        // last delivered frame
  output logic                       RX_BUSY       // a frame is being recovered
);
  import uarx_pkg::*;

  // refuse a chain too short to keep a metastable first flop away from the edge detector
  if (SYNC_STAGES < 2) begin : g_sync_check
    $error("SYNC_STAGES must be at least two");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS} uarx_state_t;

  // the whole module state, registered in one place
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;    // synchroniser chain, bit 0 is the first flop
    logic                   line_q;  // previous synchronised level for edge detection
    uarx_state_t            state;   // receiver phase
    logic [4:0]             samp;    // sample number inside the current bit
    logic [3:0]             bitn;    // bit index inside the frame after start
    logic [2:0]             votes;   // centre samples of the current bit
    logic [8:0]             shreg;   // collected data bits
    logic                   par;     // voted parity bit
    logic                   fvalid;  // delivery pulse
    uarx_frame_t            frame;   // delivered frame
  } uarx_st_t;

  uarx_st_t st_r;   // registered state
  uarx_st_t st_nxt; // next state

  // majority of three samples, shared by start and data voting
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  logic       line;      // synchronised receive level
  logic [4:0] spb;       // samples per bit in the current mode
  logic [4:0] vfirst;    // first centre sample number
  logic [3:0] nbits;     // bits after start: data, parity, first stop
  logic       voted;     // majority of the gathered centre samples
  logic       typebit;   // frame type bit of the finished frame

  assign line    = st_r.sync[SYNC_STAGES-1];
  assign spb     = CFG.double_speed_sel ? 5'(UARX_SPB_DOUBLE) : 5'(UARX_SPB_NORMAL);
  assign vfirst  = CFG.double_speed_sel ? 5'(UARX_VOTE_D_FIRST) : 5'(UARX_VOTE_N_FIRST);
  assign nbits   = CFG.char_bits + 4'(CFG.parity_en) + 4'h1;
  assign voted   = vote3(st_r.votes);

  // single next-state process for the whole receiver
  always_comb begin
    logic [8:0] shifted;
    shifted = '0;
    st_nxt        = st_r;
    st_nxt.fvalid = 1'b0;
    typebit       = 1'b0;
    // shift the raw pin through the chain; only the last stage is read
    st_nxt.sync = {st_r.sync[SYNC_STAGES-2:0], SERIAL_RX_IN};
    if (SAMPLE_TICK) begin
      st_nxt.line_q = line;
      case (st_r.state)
        ST_IDLE: begin
          // high to low seen on an idle line: this sample is number one
          if (st_r.line_q && !line) begin
            st_nxt.state = ST_START;
            st_nxt.samp  = 5'h01;
            st_nxt.votes = 3'h0;
          end
        end
        ST_START: begin
          st_nxt.samp = st_r.samp + 5'h01;
          if (st_nxt.samp >= vfirst && st_nxt.samp <= vfirst + 5'h02) begin
            st_nxt.votes = {st_r.votes[1:0], line};
          end
          if (st_r.samp == vfirst + 5'h02) begin
            if (voted) begin
              st_nxt.state = ST_IDLE;
            end else begin
              // timing now counts from this edge for the rest of the frame
              st_nxt.state = ST_BITS;
              st_nxt.bitn  = 4'h0;
            end
          end
          if (st_r.samp == spb) begin
            st_nxt.samp = 5'h01;
          end
        end
        ST_BITS: begin
          st_nxt.samp = (st_r.samp == spb) ? 5'h01 : st_r.samp + 5'h01;
          if (st_nxt.samp >= vfirst && st_nxt.samp <= vfirst + 5'h02) begin
            st_nxt.votes = {st_r.votes[1:0], line};
          end
          if (st_r.samp == vfirst + 5'h02) begin
            // bit decided by majority of its centre samples
            if (st_r.bitn < CFG.char_bits) begin
              shifted = st_r.shreg | (9'(voted) << st_r.bitn);
              st_nxt.shreg = shifted;
            end else if (CFG.parity_en && st_r.bitn == CFG.char_bits) begin
              st_nxt.par = voted;
            end
            st_nxt.bitn = st_r.bitn + 4'h1;
            if (st_r.bitn == nbits - 4'h1) begin
              // first stop bit: frame ends here, further stop bits are idle line
              typebit = (CFG.char_bits == 4'(UARX_DATA_MAX)) ? st_r.shreg[8] : voted;
              // a low on the sample right after the stop vote is already sample one of the
              // next start; the line history is not forced high, so a break held low never
              // turns into a string of false starts
              if (st_r.line_q && !line) begin
                st_nxt.state = ST_START;
                st_nxt.samp  = 5'h01;
                st_nxt.votes = 3'h0;
              end else begin
                st_nxt.state = ST_IDLE;
              end
              st_nxt.shreg  = '0;
              st_nxt.par    = 1'b0;
              // type one is an address frame; data frames are dropped when filtering
              if (!CFG.multiproc_filter_en || typebit) begin
                st_nxt.fvalid                 = 1'b1;
                st_nxt.frame.data             = st_r.shreg;
                st_nxt.frame.rx_ninth_bit     = st_r.shreg[8];
                st_nxt.frame.parity_bit       = st_r.par;
                st_nxt.frame.frame_error_flag = ~voted;
              end
            end
          end
        end
        default: begin
          st_nxt.state = ST_IDLE;
        end
      endcase
    end
  end

  // one register for all state; reset to idle with a high line history
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r        <= '0;
      st_r.sync   <= '1;
      st_r.line_q <= 1'b1;
      st_r.state  <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // FRAME_VALID and FRAME come straight from flops, RX_BUSY is decoded from the state; filtering never reaches any transmit path
  assign FRAME_VALID = st_r.fvalid;
  assign FRAME       = st_r.frame;
  assign RX_BUSY     = (st_r.state != ST_IDLE);

  // rejected start returns to idle right after the last qualification sample
  a_start_noise_reject : assert property (@(posedge CLK) disable iff (!RESETN)
    (SAMPLE_TICK && st_r.state == ST_START && st_r.samp == vfirst + 5'h02 && voted)
      |=> st_r.state == ST_IDLE)
    else $error("noise start not rejected");

  a_start_begins_one : assert property (@(posedge CLK) disable iff (!RESETN)
    (SAMPLE_TICK && st_r.state == ST_IDLE && st_r.line_q && !line)
      |=> (st_r.state == ST_START && st_r.samp == 5'h01))
    else $error("start detection did not begin at sample one");

  a_counter_holds : assert property (@(posedge CLK) disable iff (!RESETN)
    !SAMPLE_TICK |=> $stable(st_r.samp))
    else $error("sample counter moved without a tick");

  a_counter_wraps : assert property (@(posedge CLK) disable iff (!RESETN)
    (st_r.state == ST_BITS) |-> (st_r.samp >= 5'h01 && st_r.samp <= spb))
    else $error("sample number out of range");

  a_frame_error : assert property (@(posedge CLK) disable iff (!RESETN)
    FRAME_VALID |-> FRAME.frame_error_flag == ~$past(voted))
    else $error("frame error flag does not match stop vote");

  a_filter_drop : assert property (@(posedge CLK) disable iff (!RESETN)
    (FRAME_VALID && $past(CFG.multiproc_filter_en)) |->
      ($past(CFG.char_bits) == 4'(UARX_DATA_MAX) ? FRAME.rx_ninth_bit : ~FRAME.frame_error_flag))
    else $error("data frame passed the filter");

  // step one: the stop vote tick sees a fresh high to low edge on the line
  sequence s_stop_vote_edge;
    SAMPLE_TICK && st_r.state == ST_BITS && st_r.samp == vfirst + 5'h02 &&
      st_r.bitn == nbits - 4'h1 && st_r.line_q && !line;
  endsequence

  // step two: that very sample is counted as sample one of the next start bit
  sequence s_start_at_one;
    st_r.state == ST_START && st_r.samp == 5'h01;
  endsequence

  a_early_restart : assert property (@(posedge CLK) disable iff (!RESETN)
    s_stop_vote_edge |=> s_start_at_one)
    else $error("start right after the stop vote was not taken as sample one");

  a_valid_pulse : assert property (@(posedge CLK) disable iff (!RESETN)
    FRAME_VALID |=> !FRAME_VALID)
    else $error("frame valid longer than one cycle");

endmodule : uarx_recovery

// ===== shared/uarx_pkg.sv
// Purpose: shared constants and carrier types for the asynchronous receive front end
// Assumes: single 250 MHz clock, oversampling tick enable from an outside baud generator
// Notes:   sample numbers count from one at the first low sample of the start bit
package uarx_pkg;

  localparam int UARX_SPB_NORMAL   = 16;  // samples per bit, normal speed
  localparam int UARX_SPB_DOUBLE   = 8;   // samples per bit, double speed
  localparam int UARX_VOTE_N_FIRST = 8;   // first centre sample, normal speed
  localparam int UARX_VOTE_D_FIRST = 4;   // first centre sample, double speed
  localparam int UARX_DATA_MAX     = 9;   // widest character
  localparam int UARX_DATA_MIN     = 5;   // narrowest character
  localparam int UARX_SYNC_STAGES  = 2;   // receive line synchroniser depth

  // receiver configuration, steady while a frame is in flight
  typedef struct packed {
    logic       double_speed_sel;     // eight samples per bit when set
    logic       multiproc_filter_en;  // drop data frames when set
    logic       parity_en;            // a parity bit follows the data
    logic [3:0] char_bits;            // 5 to 9 data bits
  } uarx_cfg_t;

  // one recovered frame as handed to the receive buffer
  typedef struct packed {
    logic [8:0] data;              // data bits, lsb first on the line, unused upper bits zero
    logic       rx_ninth_bit;      // ninth data bit for nine bit characters
    logic       parity_bit;        // voted parity bit, zero when parity is off
    logic       frame_error_flag;  // first stop bit voted as zero
  } uarx_frame_t;

endpackage : uarx_pkg

// ===== testbench/uarx_recovery_tb_top.sv
// Purpose: self-checking bench for the receive front end
// Assumes: sample tick every fourth clock
// Notes:   expected frames are built from the data handed to the transmitter
module uarx_recovery_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uarx_pkg::*;
  logic        clk = 0, resetn = 0, tick = 0, rx_line, frame_valid, rx_busy;
  logic [1:0]  tdiv = '0;                            // tick divider
  uarx_cfg_t   cfg = '{1'b0, 1'b0, 1'b0, 4'h8};      // receiver setup
  uarx_frame_t frame;                                // delivered frame
  int          error_cnt = 0, checked = 0, pulses = 0, cyc = 0;
  always #2 clk = ~clk;
  // tick generation, pulse counting and hang guard
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    tick <= (tdiv == 2'h3);
    cyc <= cyc + 1;
    if (frame_valid === 1'b1) pulses <= pulses + 1;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  uarx_recovery DUT (.CLK(clk), .RESETN(resetn), .SAMPLE_TICK(tick), .SERIAL_RX_IN(rx_line),
    .CFG(cfg), .FRAME_VALID(frame_valid), .FRAME(frame), .RX_BUSY(rx_busy));
  uarx_tx_model TX (.CLK(clk), .TICK(tick), .LINE(rx_line));
  task automatic check(input logic [11:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  function automatic int spb;
    return cfg.double_speed_sel ? UARX_SPB_DOUBLE : UARX_SPB_NORMAL;
  endfunction : spb
  // expected frame: upper unused bits zero, error flag from the stop bit
  function automatic uarx_frame_t ef(input logic [8:0] d, input int n, input logic stop);
    uarx_frame_t f;
    f.data = d & ((9'h001 << n) - 9'h001);
    f.rx_ninth_bit = (n == 9) ? d[8] : 1'b0;
    f.parity_bit = cfg.parity_en ? ^f.data : 1'b0;
    f.frame_error_flag = ~stop;
    return f;
  endfunction : ef
  // line bits: start, data lsb first, parity, stop
  function automatic logic [11:0] mk(input logic [8:0] d, input int n, input logic stop);
    logic [11:0] b;
    uarx_frame_t f;
    b = '0;
    f = ef(d, n, stop);
    for (int i = 0; i < n; i++) b[i+1] = d[i];
    b[n+1] = f.parity_bit;
    b[n+1+int'(cfg.parity_en)] = stop;
    return b;
  endfunction : mk
  task automatic setc(input logic ds, mp, par, input logic [3:0] n);
    cfg <= '{ds, mp, par, n};
    TX.wt();
  endtask : setc
  task automatic settle(input int p0, np, input uarx_frame_t e);
    repeat (4) TX.wt();
    check(12'(pulses - p0), 12'(np));
    if (np > 0) check(frame, e);
  endtask : settle
  task automatic one(input logic [8:0] d, input int n, input logic stop, gl, input int np);
    int p0;
    p0 = pulses;
    TX.send(mk(d, n, stop), n + 2 + int'(cfg.parity_en), spb(), spb(), gl, 1'b1);
    settle(p0, np, ef(d, n, stop));
  endtask : one
  // every size at both speeds, with one centre sample inverted in each bit
  task automatic t_sizes;
    for (int s = 0; s < 2; s++) begin
      for (int n = 5; n <= 9; n++) begin
        setc(s[0], 1'b0, n[0], n[3:0]);
        one(9'h1A5, n, 1'b1, 1'b1, 1);
      end
    end
  endtask : t_sizes
  // short low spike is rejected, then a real frame still comes through
  task automatic t_noise;
    int p0;
    setc(1'b0, 1'b0, 1'b0, 4'h8);
    p0 = pulses;
    fork
      TX.send(12'h000, 1, 16, 3, 1'b0, 1'b1);
      begin
        repeat (3) TX.wt();
        check(12'(rx_busy), 12'h001);
      end
    join
    repeat (12) TX.wt();
    check(12'(rx_busy), 12'h000);
    check(12'(pulses - p0), 12'h000);
    one(9'h00F, 8, 1'b1, 1'b0, 1);
  endtask : t_noise
  // next start right after the stop vote; second frame has a bad stop
  task automatic t_b2b(input logic ds);
    int p0;
    setc(ds, 1'b0, 1'b1, 4'h9);
    p0 = pulses;
    fork
      begin
        TX.send(mk(9'h155, 9, 1'b1), 12, spb(), ds ? UARX_VOTE_D_FIRST + 2 : UARX_VOTE_N_FIRST + 2, 1'b0, 1'b0);
        TX.send(mk(9'h0AA, 9, 1'b0), 12, spb(), spb(), 1'b0, 1'b1);
      end
      begin
        // the first frame is overwritten by the second, so judge it on its own pulse
        @(posedge clk);
        while (frame_valid !== 1'b1) @(posedge clk);
        check(frame, ef(9'h155, 9, 1'b1));
      end
    join
    settle(p0, 2, ef(9'h0AA, 9, 1'b0));
  endtask : t_b2b
  // filter keeps only frames whose type bit is one
  task automatic t_filter;
    setc(1'b0, 1'b1, 1'b0, 4'h8);
    one(9'h033, 8, 1'b0, 1'b0, 0);
    one(9'h034, 8, 1'b1, 1'b0, 1);
    setc(1'b0, 1'b1, 1'b0, 4'h9);
    one(9'h055, 9, 1'b1, 1'b0, 0);
    one(9'h155, 9, 1'b1, 1'b0, 1);
    setc(1'b0, 1'b0, 1'b0, 4'h8);
    one(9'h033, 8, 1'b0, 1'b0, 1);
  endtask : t_filter
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) TX.wt();
    t_sizes();
    t_noise();
    t_b2b(1'b0);
    t_b2b(1'b1);
    t_filter();
    tally_and_finish();
  end
endmodule : uarx_recovery_tb_top

// ===== testbench/uarx_tx_model.sv
// Purpose: remote serial transmitter driving the receive line
// Assumes: each bit lasts a whole number of sample ticks
// Notes:   optional glitch inverts the middle centre sample of every bit
module uarx_tx_model (
  input  wire logic CLK,   // system clock
  input  wire logic TICK,  // sample tick enable
  output logic      LINE   // serial line, idle high
);
  timeunit 1ns;
  timeprecision 1ps;
  initial LINE = 1'b1;  // idle level
  // wait for the next edge that carries a sample tick
  task automatic wt;
    @(posedge CLK);
    while (TICK !== 1'b1) @(posedge CLK);
  endtask : wt
  // b[0] is the start bit; the last bit lasts len ticks, so a short stop
  // lets the next start follow at once
  // idle low keeps the line as it is, so a following send may start at once
  task automatic send(input logic [11:0] b, input int n, spb, len, input bit gl, idle);
    for (int i = 0; i < n; i++) begin
      for (int j = 1; j <= ((i == n - 1) ? len : spb); j++) begin
        LINE <= (gl && j == spb / 2 + 1) ? ~b[i] : b[i];
        wt();
      end
    end
    if (idle) LINE <= 1'b1;  // back to idle
  endtask : send
endmodule : uarx_tx_model
